// ---- src/cpa_regs.sv ----
// Operation
// - Filter code n gives coefficient 1/2^(n+1)
// - Common-mode shift only with bottom fine clamp
// - Fine time constant field, 00 longest
// - Fine enables green/blue and red, reset set
// - Block power-down bits, reset cleared
// - Converter channel power-down bits, reset cleared
// - Clamp bias current is 2+2N microamps
// - Coarse charge select, 00 highest current
// - Coarse clamp enables per channel, reset cleared
// - Any coarse enable disables all fine clamps
// - SOG leakage scales with clamp bias current
`timescale 1ns/1ps
`default_nettype none

module cpa_regs (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire cpa_pkg::cpa_req_t   req,
   input  wire logic                mid_level_sel,
   input  wire logic [5:0]          sog_leak_code,
   output logic [7:0]               rdata,
   output cpa_pkg::cpa_ctl_t        ctl
);
   import cpa_pkg::*;

   logic [2:0] filt_r;      // Level-control sample filter code
   logic [7:0] rsvd_r;      // Reserved byte, held as written
   logic [7:0] fine_r;      // Fine clamp setup
   logic [7:0] pwr_r;       // Block power-down
   logic [7:0] bias_r;      // Converter bias and clamp trim
   logic [7:0] coarse_r;    // Coarse clamp setup
   logic [7:0] rdata_r;     // Registered read answer
   cpa_ctl_t   ctl_r;       // Registered control levels
   cpa_ctl_t   ctl_nxt;     // Decoded control levels
   logic [7:0] rd_nxt;      // Read mux result
   logic       coarse_any;  // Some coarse clamp enabled
   logic       wr;          // Qualified write

   assign wr = ce && req.we;

   // Register writes; the whole byte is stored so reads return it intact, except the filter code, which keeps bits 2:0 only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         filt_r   <= FILT_RST;
         rsvd_r   <= RSVD_RST;
         fine_r   <= FINE_RST;
         pwr_r    <= PWR_RST;
         bias_r   <= BIAS_RST;
         coarse_r <= COARSE_RST;
      end else if (wr) begin
         unique case (req.addr)
            FILT_ADDR:   filt_r   <= req.wdata[2:0];
            RSVD_ADDR:   rsvd_r   <= req.wdata;
            FINE_ADDR:   fine_r   <= req.wdata;
            PWR_ADDR:    pwr_r    <= req.wdata;
            BIAS_ADDR:   bias_r   <= req.wdata;
            COARSE_ADDR: coarse_r <= req.wdata;
            default: begin
               // Unmapped subaddress, write ignored
            end
         endcase
      end
   end

   // Read mux; unmapped subaddresses answer zero
   always_comb begin
      unique case (req.addr)
         FILT_ADDR:   rd_nxt = {5'h00, filt_r};
         RSVD_ADDR:   rd_nxt = rsvd_r;
         FINE_ADDR:   rd_nxt = fine_r;
         PWR_ADDR:    rd_nxt = pwr_r;
         BIAS_ADDR:   rd_nxt = bias_r;
         COARSE_ADDR: rd_nxt = coarse_r;
         default:     rd_nxt = 8'h00;
      endcase
   end

   // Read answer follows the address one cycle later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 8'h00;
      end else if (ce) begin
         rdata_r <= rd_nxt;
      end
   end

   assign coarse_any = |coarse_r[COARSE_EN_LSB +: 3];

   // Decode of the stored fields into front-end controls
   always_comb begin
      ctl_nxt            = '0;
      ctl_nxt.filt_shift = {1'b0, filt_r} + 4'h1;
      // Coarse clamps win over the fine enables
      ctl_nxt.fine_en    = coarse_any ? 3'h0 :
                           {fine_r[FINE_CLAMP_GREEN_BLUE_EN_BIT], fine_r[FINE_CLAMP_GREEN_BLUE_EN_BIT],
                            fine_r[FINE_R_BIT]};
      // Offset only means something for the bottom-level fine clamp
      ctl_nxt.cm_shift   = fine_r[FINE_CM_BIT] && !coarse_any
                           && !mid_level_sel;
      ctl_nxt.fine_tc    = fine_r[FINE_TC_LSB +: 2];
      ctl_nxt.coarse_en  = coarse_r[COARSE_EN_LSB +: 3];
      ctl_nxt.coarse_chg = coarse_r[COARSE_CHG_LSB +: 2];
      ctl_nxt.blk_pd     = {pwr_r[PWR_SOG_BIT], pwr_r[PWR_SLC_BIT],
                            pwr_r[PWR_REF_BIT], pwr_r[PWR_CUR_BIT]};
      ctl_nxt.conv_pd    = pwr_r[PWR_CONV_LSB +: 3];
      ctl_nxt.conv_bias  = bias_r[BIAS_CONV_LSB +: 4];
      ctl_nxt.ibias_ua   = IBIAS_BASE_UA
                           + IBIAS_STEP_UA * {2'h0, bias_r[BIAS_TRIM_LSB +: 4]};
      // Leakage step is ibias/40 uA = (1+N)*0.05 uA per code step
      ctl_nxt.sog_leak   = 11'({1'b0, bias_r[BIAS_TRIM_LSB +: 4]} + 5'h01)
                           * {5'h00, sog_leak_code};
   end

   // Control levels are registered so the front end sees clean levels
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_r <= '0;
      end else if (ce) begin
         ctl_r <= ctl_nxt;
      end
   end

   assign rdata = rdata_r;
   assign ctl   = ctl_r;

   // Filter shift tracks the stored code
   a_filt_shift_map: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.filt_shift == 4'($past(filt_r)) + 4'h1))
      else $error("filter shift does not match code");

   // Common-mode shift never shows with coarse or mid-level clamping
   a_cm_shift_gate: assert property (@(posedge clk) disable iff (!rstn)
      (ce && (coarse_any || mid_level_sel)) |=> !ctl.cm_shift)
      else $error("common-mode shift active outside bottom fine clamp");

   // Time constant field reaches the output
   a_fine_tc_pass: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.fine_tc == $past(fine_r[4:3])))
      else $error("fine time constant not passed");

   // Fine enables follow bits with no coarse clamp on
   a_fine_en_map: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !coarse_any) |=>
         (ctl.fine_en == {$past(fine_r[1]), $past(fine_r[1]), $past(fine_r[0])}))
      else $error("fine enables do not follow register");

   // A write to power control shows two cycles later
   a_pwr_write: assert property (@(posedge clk) disable iff (!rstn)
      (wr && req.addr == PWR_ADDR) ##1 ce |=>
         (ctl.conv_pd == $past(req.wdata[2:0], 2)
          && ctl.blk_pd == $past(req.wdata[6:3], 2)))
      else $error("power-down write not applied");

   // Bias current is 2 plus 2N microamps
   a_ibias_lin: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.ibias_ua == 6'h02 + 6'($past(bias_r[3:0])) * 6'h02))
      else $error("clamp bias current wrong");

   // Coarse enable kills every fine enable
   a_coarse_wins: assert property (@(posedge clk) disable iff (!rstn)
      (ce && coarse_any) |=> (ctl.fine_en == 3'h0))
      else $error("fine clamp active with coarse clamp");

   // Coarse fields pass through
   a_coarse_map: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.coarse_chg == $past(coarse_r[7:6])
              && ctl.coarse_en == $past(coarse_r[2:0])))
      else $error("coarse fields not passed");

   // Leakage product follows trim and leakage code
   a_leak_scale: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.sog_leak == 11'($past(bias_r[3:0]) + 1) * 11'($past(sog_leak_code))))
      else $error("leakage does not scale with bias");

   // Readback of a written byte
   a_readback: assert property (@(posedge clk) disable iff (!rstn)
      (wr && req.addr == FINE_ADDR) ##1 (ce && !req.we && req.addr == FINE_ADDR)
         |=> (rdata == $past(req.wdata, 2)))
      else $error("readback differs from written value");

   // Block power-down bits pass through in order
   a_blk_pd_map: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.blk_pd == $past(pwr_r[6:3])))
      else $error("block power-down bits not passed");

   // Channel power-down bits pass through
   a_conv_pd_map: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (ctl.conv_pd == $past(pwr_r[2:0])))
      else $error("channel power-down bits not passed");

   // Filter code write keeps only the three code bits
   a_filt_store: assert property (@(posedge clk) disable iff (!rstn)
      (wr && req.addr == FILT_ADDR) |=> (filt_r == $past(req.wdata[2:0])))
      else $error("filter code not stored");

   // Offset bit shows when the bottom fine clamp is the one in use
   a_cm_shift_pass: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !coarse_any && !mid_level_sel) |=> (ctl.cm_shift == $past(fine_r[7])))
      else $error("common-mode shift not passed");

   // Unmapped subaddresses read as zero
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
      (ce && (req.addr < FILT_ADDR || req.addr > COARSE_ADDR)) |=> (rdata == 8'h00))
      else $error("unmapped subaddress read not zero");

   // Clock enable low freezes every output
   a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn)
      !ce |=> ($stable(rdata) && $stable(ctl)))
      else $error("outputs moved with clock enable low");

   // Reserved byte changes only through its own write
   a_rsvd_hold: assert property (@(posedge clk) disable iff (!rstn)
      !(wr && req.addr == RSVD_ADDR) |=> $stable(rsvd_r))
      else $error("reserved byte changed without a write");

endmodule

`default_nettype wire

// ---- src/cpa_pkg.sv ----
package cpa_pkg;

   // Subaddresses of the register group
   localparam logic [7:0] FILT_ADDR   = 8'h28;
   localparam logic [7:0] RSVD_ADDR   = 8'h29;
   localparam logic [7:0] FINE_ADDR   = 8'h2a;
   localparam logic [7:0] PWR_ADDR    = 8'h2b;
   localparam logic [7:0] BIAS_ADDR   = 8'h2c;
   localparam logic [7:0] COARSE_ADDR = 8'h2d;

   // Reset values
   localparam logic [2:0] FILT_RST    = 3'h3;
   localparam logic [7:0] RSVD_RST    = 8'h08;
   localparam logic [7:0] FINE_RST    = 8'h07;
   localparam logic [7:0] PWR_RST     = 8'h00;
   localparam logic [7:0] BIAS_RST    = 8'h50;
   localparam logic [7:0] COARSE_RST  = 8'h00;

   // Fine clamp register fields
   localparam int FINE_CM_BIT  = 7;
   localparam int FINE_TC_LSB  = 3;
   localparam int FINE_CLAMP_GREEN_BLUE_EN_BIT  = 1;
   localparam int FINE_R_BIT   = 0;

   // Power control fields
   localparam int PWR_SOG_BIT  = 6;
   localparam int PWR_SLC_BIT  = 5;
   localparam int PWR_REF_BIT  = 4;
   localparam int PWR_CUR_BIT  = 3;
   localparam int PWR_CONV_LSB = 0;

   // Converter setup fields
   localparam int BIAS_CONV_LSB = 4;
   localparam int BIAS_TRIM_LSB = 0;

   // Coarse clamp fields
   localparam int COARSE_CHG_LSB = 6;
   localparam int COARSE_EN_LSB  = 0;

   // Clamp bias current: base and step in microamps
   localparam logic [5:0] IBIAS_BASE_UA = 6'h02;
   localparam logic [5:0] IBIAS_STEP_UA = 6'h02;

   // Register access request from the serial control port
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cpa_req_t;

   // Control levels handed to the analog front end
   typedef struct packed {
      logic [3:0]  filt_shift;    // Coefficient is 1/2^filt_shift
      logic [2:0]  fine_en;       // {blue, green, red}
      logic        cm_shift;
      logic [1:0]  fine_tc;
      logic [2:0]  coarse_en;     // {blue, green, red}
      logic [1:0]  coarse_chg;
      logic [3:0]  blk_pd;        // {sog, slicer, ref, current}
      logic [2:0]  conv_pd;       // {blue, green, red}
      logic [3:0]  conv_bias;
      logic [5:0]  ibias_ua;
      logic [10:0] sog_leak;      // Droop above 0.01 uA, in 0.05 uA steps
   } cpa_ctl_t;

endpackage

// ---- sim/cpa_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpa_host (
   input  wire logic        clk,
   input  wire logic [7:0]  rdata,
   output var cpa_pkg::cpa_req_t req
);
   import cpa_pkg::*;

   // Idle port: no strobe
   initial req = '0;

   // One-cycle write strobe, data scrambled once released
   // Software keeps the reserved byte and reserved coarse bits as required
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] sent;  // Byte as software really sends it
      sent = v;
      if (a == RSVD_ADDR) begin
         sent = RSVD_RST;
      end
      if (a == COARSE_ADDR) begin
         sent[5:3] = 3'h0;
      end
      @(negedge clk);
      req = '{1'b1, a, sent};
      @(negedge clk);
      req.we = 1'b0;
      req.wdata = ~sent;
   endtask

   // Park address, let the registered answer land
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      req.addr = a;
      repeat (2) @(negedge clk);
      v = rdata;
   endtask
endmodule

`default_nettype wire

// ---- sim/tb_clamp_power_adc_setup_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_clamp_power_adc_setup_regs;
   import cpa_pkg::*;
   logic       clk = 1'b0;    // 100 MHz clock
   logic       rstn = 1'b0;   // Held low at start
   logic       ce = 1'b0;     // Clock enable
   logic       mid_sel = 1'b0; // Mid-level clamp chosen
   logic [5:0] leak = 6'h3f;  // Leakage code, top value
   logic [7:0] rdata;         // Read byte from bank
   logic [7:0] d;             // Scratch byte
   cpa_req_t   req;           // Host request
   cpa_ctl_t   ctl;           // Front-end controls
   int         failures = 0;  // Mismatches
   int         checks = 0;    // Comparisons

   always #5 clk = ~clk;

   cpa_regs dut_u (.clk(clk), .rstn(rstn), .ce(ce), .req(req),
      .mid_level_sel(mid_sel), .sog_leak_code(leak), .rdata(rdata), .ctl(ctl));
   cpa_host host_u (.clk(clk), .rdata(rdata), .req(req));

   // Compare one value, four-state exact
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read back a byte and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, d);
      chk(16'(d), 16'(e));
   endtask

   // Write, then give the decoded levels two edges to follow
   task automatic wset(input logic [7:0] a, input logic [7:0] v);
      host_u.wr(a, v);
      repeat (2) @(negedge clk);
   endtask

   // Defaults after reset
   task automatic t_reset();
      rchk(8'h28, 8'h03);
      rchk(8'h29, 8'h08);
      rchk(8'h2a, 8'h07);
      rchk(8'h2b, 8'h00);
      rchk(8'h2c, 8'h50);
      rchk(8'h2d, 8'h00);
      chk(16'(ctl.filt_shift), 16'h4);
      chk(16'({ctl.fine_en, ctl.cm_shift, ctl.fine_tc}), 16'h38);
      chk(16'({ctl.blk_pd, ctl.conv_pd}), 16'h0);
      chk(16'({ctl.coarse_chg, ctl.coarse_en}), 16'h0);
      chk(16'(ctl.ibias_ua), 16'h2);
   endtask

   // Every filter code, shift is code plus one
   task automatic t_filter();
      for (int n = 0; n < 8; n++) begin
         wset(8'h28, 8'(n));
         chk(16'(ctl.filt_shift), 16'(n + 1));
      end
      rchk(8'h28, 8'h07);
   endtask

   // Block power-down bits on, then block bits off with channel bits on; reserved top bit stored
   task automatic t_power();
      wset(8'h2b, 8'h78);
      chk(16'({ctl.blk_pd, ctl.conv_pd}), 16'h78);
      wset(8'h2b, 8'h87);
      chk(16'({ctl.blk_pd, ctl.conv_pd}), 16'h07);
      rchk(8'h2b, 8'h87);
   endtask

   // Clock enable low: a write does not land and the outputs hold
   task automatic t_freeze();
      ce = 1'b0;
      host_u.wr(8'h2a, 8'h00);
      repeat (2) @(negedge clk);
      chk(16'(rdata), 16'h87);
      chk(16'(ctl.fine_en), 16'h7);
      ce = 1'b1;
      rchk(8'h2a, 8'h07);
   endtask

   // Trim ends and middles; bias and leakage follow it
   task automatic t_bias();
      for (int n = 0; n < 16; n += 5) begin
         wset(8'h2c, {4'h8, 4'(n)});
         chk(16'(ctl.conv_bias), 16'h8);
         chk(16'(ctl.ibias_ua), 16'(2 + 2 * n));
         chk(16'(ctl.sog_leak), 16'((n + 1) * 63));
      end
      leak = 6'h04;
      wset(8'h2c, 8'h53);
      chk(16'(ctl.ibias_ua), 16'h8);
      chk(16'(ctl.sog_leak), 16'h10);
      leak = 6'h3f;
   endtask

   // Fine clamp fields, offset gating, coarse override, unmapped place
   task automatic t_clamp();
      wset(8'h2a, 8'h9f);
      chk(16'({ctl.fine_en, ctl.cm_shift, ctl.fine_tc}), 16'h3f);
      mid_sel = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(ctl.cm_shift), 16'h0);
      mid_sel = 1'b0;
      wset(8'h2d, 8'hfc);
      chk(16'({ctl.coarse_chg, ctl.coarse_en, ctl.fine_en, ctl.cm_shift}), 16'h1c0);
      wset(8'h40, 8'hff);
      rchk(8'h40, 8'h00);
      rchk(8'h2d, 8'hc4);
      wset(8'h2d, 8'h00);
      chk(16'(ctl.fine_en), 16'h7);
      host_u.wr(8'h29, 8'h00);
      rchk(8'h29, 8'h08);
   endtask

   // Reset in mid-run after writes: outputs clear, defaults return
   task automatic t_rerst();
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      chk(16'(rdata), 16'h0);
      chk(16'(|ctl), 16'h0);
      rstn = 1'b1;
      t_reset();
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      ce = 1'b1;
      t_reset();
      t_filter();
      t_power();
      t_freeze();
      t_bias();
      t_clamp();
      t_rerst();
      print_verdict();
   end

   // Watchdog, tests take well under 1000 cycles
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule

`default_nettype wire
